// file: rtl/mdpc_regs.vh
// Register offsets, field positions, reset values and timing for the block
// Contract
// - An active switching pulse ends at the first of maximum time elapsed, motor-running seen, or tap position changed.
// - After every pulse a configurable pause runs, and no new pulse starts while it runs.
// - The block measures how long motor-running stays high against a configurable runtime limit.
// - When the runtime limit is exceeded, the block raises a runtime event first and then pulses the trip output; here both are set on the same edge.
// - Runtime supervision has an enable; while disabled neither the event nor the trip pulse occurs.
// - With direction supervision on, a tap change opposite to the command raises a direction fault and blocks automatic regulation.
// - Automatic regulation stays blocked until the direction fault is acknowledged.
// - Continuous pulse mode turns direction supervision off, so no direction fault arises there.
// - Standard direction drives raise to increase voltage and lower to decrease it.
// - Swapped direction drives lower to increase voltage and raise to decrease it.
// - In continuous mode under automatic control the pulse is held until the value is back in band, with the pause still enforced.
`ifndef MDPC_REGS_VH
`define MDPC_REGS_VH
`define MDPC_ADDR_CTRL 8'h00
`define MDPC_ADDR_PULSE 8'h04
`define MDPC_ADDR_PAUSE 8'h08
`define MDPC_ADDR_RUNLIM 8'h0c
`define MDPC_ADDR_STATUS 8'h10
`define MDPC_ADDR_MASK 8'h14
`define MDPC_ADDR_STATE 8'h18
`define MDPC_CTRL_CONT 0
`define MDPC_CTRL_SWAP 1
`define MDPC_CTRL_RUN_EN 2
`define MDPC_CTRL_DIR_EN 3
`define MDPC_CTRL_AUTO 4
`define MDPC_ST_RUNTIME 0
`define MDPC_ST_DIRFLT 1
`define MDPC_ST_PULSE_END 2
`define MDPC_PULSE_RST 16'd1500
`define MDPC_PAUSE_RST 16'd1000
`define MDPC_RUNLIM_RST 16'd15000
`define MDPC_TICK_NS 1000000
`define MDPC_CLK_NS 5
`define MDPC_TICK_CYC (`MDPC_TICK_NS / `MDPC_CLK_NS)
`define MDPC_TRIP_MS 16'd500
`endif

// file: rtl/mdpc_tick.v
// Timebase divider producing a one-cycle tick enable
`timescale 1ns/1ps
module mdpc_tick #(
  parameter DIV = 200000
) (
  input wire clk_i,
  input wire rst_i,
  output reg tick_o
);
  reg [31:0] cnt_reg;
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 32'h0;
      tick_o <= 1'b0;
    end else if (cnt_reg == DIV - 1) begin
      cnt_reg <= 32'h0;
      tick_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
      tick_o <= 1'b0;
    end
  end
endmodule

// file: rtl/mdpc_top.v
// Motor-drive switching pulse, runtime and direction supervision
`timescale 1ns/1ps
`include "mdpc_regs.vh"
module mdpc_top #(
  parameter TICK_CYC = `MDPC_TICK_CYC
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire req_inc_i,
  input wire req_dec_i,
  input wire in_band_i,
  input wire ack_dir_i,
  input wire motor_run_i,
  input wire tap_up_i,
  input wire tap_down_i,
  output reg raise_o,
  output reg lower_o,
  output reg trip_o,
  output reg auto_block_o,
  output wire irq_o
);
  localparam S_IDLE = 2'd0;
  localparam S_PULSE = 2'd1;
  localparam S_PAUSE = 2'd2;

  reg [4:0] ctrl_reg;
  reg [15:0] pulse_set_reg;
  reg [15:0] pause_set_reg;
  reg [15:0] runlim_reg;
  reg [2:0] status_reg;
  reg [2:0] mask_reg;
  reg [1:0] state_reg;
  reg [15:0] tmr_reg;
  reg [15:0] run_cnt_reg;
  reg [15:0] trip_cnt_reg;
  reg run_flag_reg;
  reg cmd_inc_reg;
  reg block_reg;
  reg [1:0] mr_sync_reg;
  reg [1:0] up_sync_reg;
  reg [1:0] dn_sync_reg;
  reg mr_d_reg;
  reg up_d_reg;
  reg dn_d_reg;
  reg [2:0] ev_set;
  wire tick;
  wire wr;
  wire rd_ack;
  wire mr;
  wire up_edge;
  wire dn_edge;
  wire tap_chg;
  wire cont;
  wire go_inc;
  wire go_dec;
  wire pulse_end;

  mdpc_tick #(
    .DIV(TICK_CYC)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  // Pins from the motor-drive unit cross into our clock
  always @(posedge clk_i) begin
    if (rst_i) begin
      mr_sync_reg <= 2'b00;
      up_sync_reg <= 2'b00;
      dn_sync_reg <= 2'b00;
      mr_d_reg <= 1'b0;
      up_d_reg <= 1'b0;
      dn_d_reg <= 1'b0;
    end else begin
      mr_sync_reg <= {mr_sync_reg[0], motor_run_i};
      up_sync_reg <= {up_sync_reg[0], tap_up_i};
      dn_sync_reg <= {dn_sync_reg[0], tap_down_i};
      mr_d_reg <= mr_sync_reg[1];
      up_d_reg <= up_sync_reg[1];
      dn_d_reg <= dn_sync_reg[1];
    end
  end

  assign mr = mr_sync_reg[1];
  assign up_edge = up_sync_reg[1] & ~up_d_reg;
  assign dn_edge = dn_sync_reg[1] & ~dn_d_reg;
  assign tap_chg = up_edge | dn_edge;
  assign cont = ctrl_reg[`MDPC_CTRL_CONT];
  // Automatic requests are refused while blocked; manual ones pass
  assign go_inc = req_inc_i & ~(block_reg & ctrl_reg[`MDPC_CTRL_AUTO]);
  assign go_dec = req_dec_i & ~go_inc &
    ~(block_reg & ctrl_reg[`MDPC_CTRL_AUTO]);

  // Continuous mode ends on in-band (auto) or request release (manual), timed mode on the pulse timer, motor-run rise or tap change
  assign pulse_end = cont ?
    (ctrl_reg[`MDPC_CTRL_AUTO] ? in_band_i : ~(req_inc_i | req_dec_i)) :
    ((tick && tmr_reg <= 16'd1) || (mr & ~mr_d_reg) || tap_chg);

  // Pulse sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
      tmr_reg <= 16'h0;
      cmd_inc_reg <= 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (go_inc | go_dec) begin
            state_reg <= S_PULSE;
            tmr_reg <= pulse_set_reg;
            cmd_inc_reg <= go_inc;
          end
        end
        S_PULSE: begin
          if (pulse_end) begin
            state_reg <= S_PAUSE;
            tmr_reg <= pause_set_reg;
          end else if (tick) begin
            tmr_reg <= tmr_reg - 16'd1;
          end
        end
        S_PAUSE: begin
          if (tmr_reg == 16'd0) begin
            state_reg <= S_IDLE;
          end else if (tick) begin
            tmr_reg <= tmr_reg - 16'd1;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // Output steering
  always @(posedge clk_i) begin
    if (rst_i) begin
      raise_o <= 1'b0;
      lower_o <= 1'b0;
    end else if (state_reg == S_PULSE && !pulse_end) begin
      if (ctrl_reg[`MDPC_CTRL_SWAP]) begin
        raise_o <= ~cmd_inc_reg;
        lower_o <= cmd_inc_reg;
      end else begin
        raise_o <= cmd_inc_reg;
        lower_o <= ~cmd_inc_reg;
      end
    end else begin
      raise_o <= 1'b0;
      lower_o <= 1'b0;
    end
  end

  // Runtime supervision, counted in ticks; one event per run
  always @(posedge clk_i) begin
    if (rst_i) begin
      run_cnt_reg <= 16'h0;
      run_flag_reg <= 1'b0;
      trip_cnt_reg <= 16'h0;
      trip_o <= 1'b0;
    end else begin
      if (!mr || !ctrl_reg[`MDPC_CTRL_RUN_EN]) begin
        run_cnt_reg <= runlim_reg;
        run_flag_reg <= 1'b0;
      end else if (tick && !run_flag_reg) begin
        if (run_cnt_reg == 16'd0) begin
          run_flag_reg <= 1'b1;
        end else begin
          run_cnt_reg <= run_cnt_reg - 16'd1;
        end
      end
      // Trip is set on the same edge as the runtime status bit
      if (ev_set[`MDPC_ST_RUNTIME]) begin
        trip_o <= 1'b1;
        trip_cnt_reg <= `MDPC_TRIP_MS;
      end else if (trip_o && tick) begin
        if (trip_cnt_reg <= 16'd1) begin
          trip_o <= 1'b0;
        end
        trip_cnt_reg <= trip_cnt_reg - 16'd1;
      end
    end
  end

  // Event detection
  always @* begin
    ev_set = 3'b000;
    ev_set[`MDPC_ST_RUNTIME] = tick & mr & ~run_flag_reg &
      ctrl_reg[`MDPC_CTRL_RUN_EN] & (run_cnt_reg == 16'd0);
    ev_set[`MDPC_ST_DIRFLT] = ctrl_reg[`MDPC_CTRL_DIR_EN] & ~cont &
      (state_reg != S_IDLE) &
      ((cmd_inc_reg & dn_edge) | (~cmd_inc_reg & up_edge));
    ev_set[`MDPC_ST_PULSE_END] = (state_reg == S_PULSE) & pulse_end;
  end

  // Blocking holds until software or a pin acknowledges
  always @(posedge clk_i) begin
    if (rst_i) begin
      block_reg <= 1'b0;
      auto_block_o <= 1'b0;
    end else begin
      if (ev_set[`MDPC_ST_DIRFLT]) begin
        block_reg <= 1'b1;
      end else if (ack_dir_i || !status_reg[`MDPC_ST_DIRFLT]) begin
        block_reg <= 1'b0;
      end
      auto_block_o <= block_reg;
    end
  end

  // Wishbone slave, ack one cycle after the strobe
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign rd_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  function [15:0] merge16;
    input [15:0] old;
    input [31:0] dat;
    input [3:0] sel;
    begin
      merge16 = {sel[1] ? dat[15:8] : old[15:8],
        sel[0] ? dat[7:0] : old[7:0]};
    end
  endfunction

  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= 5'h0;
      pulse_set_reg <= `MDPC_PULSE_RST;
      pause_set_reg <= `MDPC_PAUSE_RST;
      runlim_reg <= `MDPC_RUNLIM_RST;
      mask_reg <= 3'h0;
      status_reg <= 3'h0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= rd_ack;
      if (wr) begin
        case (wb_adr_i)
          `MDPC_ADDR_CTRL: begin
            if (wb_sel_i[0]) begin
              ctrl_reg <= wb_dat_i[4:0];
            end
          end
          `MDPC_ADDR_PULSE: begin
            pulse_set_reg <= merge16(pulse_set_reg, wb_dat_i, wb_sel_i);
          end
          `MDPC_ADDR_PAUSE: begin
            pause_set_reg <= merge16(pause_set_reg, wb_dat_i, wb_sel_i);
          end
          `MDPC_ADDR_RUNLIM: begin
            runlim_reg <= merge16(runlim_reg, wb_dat_i, wb_sel_i);
          end
          `MDPC_ADDR_MASK: begin
            if (wb_sel_i[0]) begin
              mask_reg <= wb_dat_i[2:0];
            end
          end
          default: begin
          end
        endcase
      end
      // Set beats clear in the same cycle
      if (wr && wb_adr_i == `MDPC_ADDR_STATUS && wb_sel_i[0]) begin
        status_reg <= (status_reg & ~wb_dat_i[2:0]) | ev_set;
      end else if (ack_dir_i) begin
        status_reg <= (status_reg & ~(3'b001 << `MDPC_ST_DIRFLT)) | ev_set;
      end else begin
        status_reg <= status_reg | ev_set;
      end
      case (wb_adr_i)
        `MDPC_ADDR_CTRL: wb_dat_o <= {27'h0, ctrl_reg};
        `MDPC_ADDR_PULSE: wb_dat_o <= {16'h0, pulse_set_reg};
        `MDPC_ADDR_PAUSE: wb_dat_o <= {16'h0, pause_set_reg};
        `MDPC_ADDR_RUNLIM: wb_dat_o <= {16'h0, runlim_reg};
        `MDPC_ADDR_STATUS: wb_dat_o <= {29'h0, status_reg};
        `MDPC_ADDR_MASK: wb_dat_o <= {29'h0, mask_reg};
        `MDPC_ADDR_STATE: wb_dat_o <= {24'h0, block_reg, trip_o, mr,
          cmd_inc_reg, 2'b00, state_reg};
        default: wb_dat_o <= 32'h0;
      endcase
    end
  end

  assign irq_o = |(status_reg & mask_reg);
endmodule

// file: sim/mdpc_props_properties.sv
// Port assertions for the motor-drive pulse control block
`timescale 1ns/1ps
module mdpc_props #(
  parameter TICK_CYC = 10
) (
  input logic clk_i,
  input logic rst_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [7:0] wb_adr_i,
  input logic [31:0] wb_dat_o,
  input logic wb_ack_o,
  input logic req_inc_i,
  input logic req_dec_i,
  input logic ack_dir_i,
  input logic raise_o,
  input logic lower_o,
  input logic trip_o,
  input logic auto_block_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus cycle not answered");
  chk_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i
    && !wb_ack_o && wb_adr_i == 8'h1c |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_out_excl: assert property (!(raise_o && lower_o))
    else $error("raise and lower together");
  chk_pulse_cause: assert property ($rose(raise_o) || $rose(lower_o)
    |-> $past(req_inc_i || req_dec_i))
    else $error("pulse without request");
  chk_pause_gap: assert property ($fell(raise_o || lower_o)
    |-> !(raise_o || lower_o) [*8])
    else $error("pulse inside pause");
  chk_trip_hold: assert property ($rose(trip_o) |=> trip_o [*8])
    else $error("trip pulse too short");
  // Software clear and late acknowledge both excluded, any may release
  chk_block_hold: assert property (auto_block_o && !ack_dir_i
    && !$past(ack_dir_i) && !wb_cyc_i && !$past(wb_cyc_i) |=> auto_block_o)
    else $error("block dropped without acknowledge");
  cover property ($rose(trip_o));
  cover property ($rose(auto_block_o));
  cover property ($rose(lower_o));
endmodule
bind mdpc_top mdpc_props #(.TICK_CYC(TICK_CYC)) u_mdpc_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .req_inc_i(req_inc_i), .req_dec_i(req_dec_i),
  .ack_dir_i(ack_dir_i), .raise_o(raise_o), .lower_o(lower_o),
  .trip_o(trip_o), .auto_block_o(auto_block_o));

// file: sim/mdpc_motor_model.sv
// Behavioural motor-drive unit answering raise and lower commands
`timescale 1ns/1ps
module mdpc_motor_model (
  input wire logic clk_i,
  input wire logic raise_i,
  input wire logic lower_i,
  input wire logic wrong_i,
  input wire logic [15:0] run_cyc_i,
  output logic motor_run_o,
  output logic tap_up_o,
  output logic tap_down_o
);
  logic up;
  initial begin
    motor_run_o = 1'b0;
    tap_up_o = 1'b0;
    tap_down_o = 1'b0;
  end
  always begin
    @(posedge clk_i);
    if (raise_i || lower_i) begin
      // A miswired unit moves the tap the other way
      up = raise_i ^ wrong_i;
      repeat (3) @(posedge clk_i);
      motor_run_o <= 1'b1;
      repeat (run_cyc_i) @(posedge clk_i);
      tap_up_o <= up;
      tap_down_o <= !up;
      @(posedge clk_i);
      motor_run_o <= 1'b0;
      tap_up_o <= 1'b0;
      tap_down_o <= 1'b0;
      while (raise_i || lower_i) @(posedge clk_i);
    end
  end
endmodule

// file: sim/mdpc_top_tb.sv
// Self-checking bench for the motor-drive pulse control block
`timescale 1ns/1ps
module mdpc_top_tb;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, req_inc_i, req_dec_i;
  logic in_band_i, ack_dir_i, wrong, swap;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, q;
  logic [15:0] run_cyc;
  logic [16:0] lfsr;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, raise_o, lower_o, trip_o, auto_block_o, irq_o;
  wire motor_run_i, tap_up_i, tap_down_i;
  integer errors = 0, checks_done = 0, len, st_m, seen;
  logic [1:0] exp_q[$];
  mdpc_top #(.TICK_CYC(10)) u_mdpc_top (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .req_inc_i(req_inc_i),
    .req_dec_i(req_dec_i), .in_band_i(in_band_i), .ack_dir_i(ack_dir_i),
    .motor_run_i(motor_run_i), .tap_up_i(tap_up_i), .tap_down_i(tap_down_i),
    .raise_o(raise_o), .lower_o(lower_o), .trip_o(trip_o),
    .auto_block_o(auto_block_o), .irq_o(irq_o));
  mdpc_motor_model u_mdpc_motor_model (.clk_i(clk_i), .raise_i(raise_o),
    .lower_i(lower_o), .wrong_i(wrong), .run_cyc_i(run_cyc),
    .motor_run_o(motor_run_i), .tap_up_o(tap_up_i), .tap_down_o(tap_down_i));
  function logic [16:0] lfsr_next(input logic [16:0] s);
    lfsr_next = {s[15:0], s[16] ^ s[13]};
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    integer n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    chk(n < 20, 1);
    @(posedge clk_i);
  endtask
  // Request is dropped at once, so only the block decides the pulse end
  task pulse(input integer inc, input integer rl, output integer ln);
    integer n;
    n = 0;
    run_cyc <= rl;
    exp_q.push_back((inc != 0) ^ swap ? 2'b10 : 2'b01);
    if (inc != 0) req_inc_i <= 1'b1;
    else req_dec_i <= 1'b1;
    do begin @(posedge clk_i); n++; end while (!(raise_o | lower_o) && n < 200);
    chk({raise_o, lower_o}, exp_q.pop_front());
    req_inc_i <= 1'b0;
    req_dec_i <= 1'b0;
    ln = 0;
    while ((raise_o | lower_o) && ln < 500) begin @(posedge clk_i); ln++; end
  endtask
  task note(input string s);
    $display("test %s done", s);
  endtask
  task final_report;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    repeat (30000) @(posedge clk_i);
    errors++;
    final_report;
  end
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, req_inc_i, req_dec_i} = 6'h20;
    {in_band_i, ack_dir_i, wrong, swap} = 4'h0;
    {wb_adr_i, wb_dat_i, wb_sel_i, run_cyc} = {8'h0, 32'h0, 4'hf, 16'd8};
    lfsr = 17'd68095;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(0, 8'h04, 0); chk(q, 1500);
    wb(0, 8'h08, 0); chk(q, 1000);
    wb(0, 8'h0c, 0); chk(q, 15000);
    wb(0, 8'h1c, 0); chk(q, 0);
    wb(1, 8'h04, 4); wb(1, 8'h08, 5); wb(1, 8'h0c, 5); wb(1, 8'h14, 3);
    note("reset");
    for (int s = 0; s < 4; s++) begin
      swap = s[1];
      lfsr = lfsr_next(lfsr);
      wb(1, 8'h00, 32'h4 | (s[1] << 1));
      pulse(s[0], 4 + lfsr[3:0], len); chk(len < 15, 1);
      repeat (80) @(posedge clk_i);
    end
    swap = 0;
    note("direction");
    wb(1, 8'h00, 4); pulse(1, 150, len);
    for (int i = 0; i < 300 && !trip_o; i++) @(posedge clk_i);
    st_m = 1;
    chk(trip_o, 1);
    wb(0, 8'h10, 0); chk(q & 3, st_m);
    chk(irq_o, 1);
    wb(1, 8'h14, 0); chk(irq_o, 0);
    wb(1, 8'h14, 3); wb(1, 8'h10, 7); st_m = 0; chk(irq_o, 0);
    note("runtime");
    wb(1, 8'h00, 0); pulse(1, 150, len); repeat (200) @(posedge clk_i);
    wb(0, 8'h10, 0); chk(q & 3, st_m);
    note("runtime off");
    wrong = 1'b1;
    wb(1, 8'h00, 32'h18); pulse(1, 8, len); repeat (40) @(posedge clk_i);
    st_m = 2;
    chk(auto_block_o, 1);
    wb(0, 8'h10, 0); chk(q & 3, st_m);
    chk(irq_o, 1);
    seen = 0;
    req_inc_i <= 1'b1;
    repeat (100) begin @(posedge clk_i); seen |= raise_o | lower_o; end
    req_inc_i <= 1'b0;
    chk(seen, 0);
    ack_dir_i <= 1'b1;
    @(posedge clk_i);
    ack_dir_i <= 1'b0;
    // Block register clears one edge after the ack, its output one more
    repeat (3) @(posedge clk_i);
    chk(auto_block_o, 0);
    wb(1, 8'h10, 7); st_m = 0; repeat (80) @(posedge clk_i);
    note("direction fault");
    wb(1, 8'h00, 32'h19);
    fork begin repeat (100) @(posedge clk_i); in_band_i <= 1'b1; end join_none
    pulse(1, 8, len); chk(len > 90 && len < 110, 1);
    repeat (30) @(posedge clk_i);
    chk(auto_block_o, 0);
    wb(0, 8'h10, 0); chk(q & 3, st_m);
    in_band_i <= 1'b0;
    note("continuous");
    final_report;
  end
endmodule
